//--- include/mmtw_pkg.sv
// constants, types and helpers of the two-wire management target
package mmtw_pkg;
  // fixed upper seven bits of a control byte
  localparam logic [6:0] CTRL_FIXED = 7'h50;
  // control byte bit that selects a read
  localparam int CTRL_RW_BIT = 0;
  // current byte address after reset
  localparam logic [7:0] ADDR_RESET = 8'h00;
  // bytes of a page and bits of the in-page offset
  localparam int PAGE_BITS = 7;
  localparam logic [7:0] PAGE_BYTES = 8'h80;
  // system clock rate
  localparam int CLK_MHZ = 50;
  // write hold limits, microseconds (plain defaults)
  localparam int NONVOLATILE_WRITE_HOLD_LIMIT_US = 10000;
  localparam int VOLATILE_WRITE_HOLD_LIMIT_US = 100;
  // same limits in system clock cycles
  localparam int NONVOLATILE_WRITE_HOLD_CYCLES = NONVOLATILE_WRITE_HOLD_LIMIT_US * CLK_MHZ;
  localparam int VOLATILE_WRITE_HOLD_CYCLES = VOLATILE_WRITE_HOLD_LIMIT_US * CLK_MHZ;
  // cycles kept back from a limit for the handshake crossing
  localparam int SYNC_MARGIN_CYCLES = 8;
  // link engine states
  typedef enum logic [8:0] {
    LS_IDLE = 9'h001,
    LS_CTRL = 9'h002,
    LS_CTRL_ACK = 9'h004,
    LS_ADDR = 9'h008,
    LS_ADDR_ACK = 9'h010,
    LS_WDATA = 9'h020,
    LS_WDATA_ACK = 9'h040,
    LS_RDATA = 9'h080,
    LS_RACK = 9'h100
  } mmtw_link_state_t;
  // commit engine states
  typedef enum logic [2:0] {
    CS_IDLE = 3'h1,
    CS_WRITE = 3'h2,
    CS_WAIT = 3'h4
  } mmtw_commit_state_t;
  // add within the page, upper address bit untouched
  function automatic logic [7:0] page_add(input logic [7:0] a, input logic [7:0] n);
    logic [6:0] low;
    low = a[6:0] + n[6:0];
    return {a[7], low};
  endfunction
endpackage

//--- rtl/mmtw_target.sv
// two-wire management target: link engine, write buffer and commit engine
`timescale 1ns/1ns
`default_nettype none
module mmtw_target #(
  parameter int NV_HOLD_CYCLES = mmtw_pkg::NONVOLATILE_WRITE_HOLD_CYCLES,
  parameter int VOL_HOLD_CYCLES = mmtw_pkg::VOLATILE_WRITE_HOLD_CYCLES
) (
  // system clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // link sampling clock
  input wire logic link_clk_i,
  // two-wire pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // storage read port
  output logic [7:0] mem_raddr_o,
  input wire logic [7:0] mem_rdata_i,
  // storage write port
  output logic mem_we_o,
  output logic [7:0] mem_waddr_o,
  output logic [7:0] mem_wdata_o,
  input wire logic mem_nonvolatile_i,
  input wire logic mem_busy_i,
  // status
  output logic holdoff_o
);
  // ---------------- link domain ----------------
  logic scl_s1, scl_s2, scl_q; // scl synchroniser and previous
  logic sda_s1, sda_s2, sda_q; // sda synchroniser and previous
  mmtw_pkg::mmtw_link_state_t state; // link engine state
  logic [3:0] bit_cnt; // bits of current byte
  logic [7:0] shreg; // shift register
  logic [7:0] cur_addr; // current byte address
  logic sda_drive; // pulling sda low
  logic rd_mode; // control byte asked for a read
  logic mack; // initiator acknowledged last byte
  logic read_sent; // read ended by NACK, waits STOP
  logic [7:0] wr_base; // first address of write burst
  logic [6:0] wr_count; // bytes taken in burst, mod page
  logic wr_full; // a whole page or more taken
  logic [7:0] wbuf [0:127]; // page write buffer
  logic rd_req; // read request toggle
  logic [7:0] rd_addr; // address of requested byte
  logic rd_ack_s1, rd_ack_s2, rd_ack_q; // read answer sync
  logic [7:0] rd_data_l; // byte ready to send
  logic cm_req; // commit request toggle
  logic [7:0] cm_cnt; // burst length handed over with the commit request
  logic cm_ack_s1, cm_ack_s2; // commit answer sync
  // clk-domain signals seen across
  logic rd_ack; // read answer toggle
  logic [7:0] rd_data_x; // fetched byte
  logic cm_ack; // commit answer toggle

  // bus events from the synchronised pins
  wire scl_rise = scl_s2 & ~scl_q;
  wire scl_fall = ~scl_s2 & scl_q;
  wire start_det = scl_s2 & scl_q & sda_q & ~sda_s2;
  wire stop_det = scl_s2 & scl_q & ~sda_q & sda_s2;
  wire byte_done = scl_fall & (bit_cnt == 4'h8);
  wire busy = cm_req ^ cm_ack_s2;
  wire ctrl_match = (shreg[7:1] == mmtw_pkg::CTRL_FIXED);
  wire write_pending = (wr_count != 7'h00) | wr_full;
  wire [7:0] next_addr_inc = mmtw_pkg::page_add(cur_addr, 8'h01);
  wire [7:0] burst_end = mmtw_pkg::page_add(wr_base, {1'b0, wr_count});
  wire [6:0] wbuf_idx = burst_end[6:0];
  wire rd_new = rd_ack_s2 ^ rd_ack_q;

  // pin and answer synchronisers
  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_q <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_q <= 1'b1;
      rd_ack_s1 <= 1'b0;
      rd_ack_s2 <= 1'b0;
      rd_ack_q <= 1'b0;
      cm_ack_s1 <= 1'b0;
      cm_ack_s2 <= 1'b0;
    end
    else
    begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_q <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_q <= sda_s2;
      rd_ack_s1 <= rd_ack;
      rd_ack_s2 <= rd_ack_s1;
      rd_ack_q <= rd_ack_s2;
      cm_ack_s1 <= cm_ack;
      cm_ack_s2 <= cm_ack_s1;
    end
  end

  // fetched byte caught when its answer arrives
  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
      rd_data_l <= 8'h00;
    else if (rd_new)
      rd_data_l <= rd_data_x;
  end

  // write buffer, filled only on acknowledged data
  always_ff @(posedge link_clk_i)
  begin
    if (state == mmtw_pkg::LS_WDATA && byte_done)
      wbuf[wbuf_idx] <= shreg;
  end

  // link engine
  always_ff @(posedge link_clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      state <= mmtw_pkg::LS_IDLE;
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
      cur_addr <= mmtw_pkg::ADDR_RESET;
      sda_drive <= 1'b0;
      rd_mode <= 1'b0;
      mack <= 1'b0;
      read_sent <= 1'b0;
      wr_base <= 8'h00;
      wr_count <= 7'h00;
      wr_full <= 1'b0;
      rd_req <= 1'b0;
      rd_addr <= 8'h00;
      cm_req <= 1'b0;
      cm_cnt <= 8'h00;
    end
    else if (start_det)
    begin
      // restart: partial byte and uncommitted data dropped, address kept
      state <= mmtw_pkg::LS_CTRL;
      bit_cnt <= 4'h0;
      sda_drive <= 1'b0;
      read_sent <= 1'b0;
      wr_count <= 7'h00;
      wr_full <= 1'b0;
    end
    else if (stop_det)
    begin
      state <= mmtw_pkg::LS_IDLE;
      bit_cnt <= 4'h0;
      sda_drive <= 1'b0;
      read_sent <= 1'b0;
      wr_count <= 7'h00;
      wr_full <= 1'b0;
      if (state == mmtw_pkg::LS_WDATA && bit_cnt <= 4'h1 && write_pending)
      begin
        // orderly write end: commit now, address past last byte
        cm_req <= ~cm_req;
        // length latched here: the burst counters clear at this same edge
        cm_cnt <= wr_full ? mmtw_pkg::PAGE_BYTES : {1'b0, wr_count};
        cur_addr <= burst_end;
      end
      else if (read_sent)
        cur_addr <= next_addr_inc;
    end
    else
    begin
      case (state)
        mmtw_pkg::LS_CTRL, mmtw_pkg::LS_ADDR, mmtw_pkg::LS_WDATA:
        begin
          // receive, msb first, sampled on scl rise
          if (scl_rise)
          begin
            shreg <= {shreg[6:0], sda_s2};
            bit_cnt <= bit_cnt + 4'h1;
          end
          else if (byte_done)
          begin
            bit_cnt <= 4'h0;
            if (state == mmtw_pkg::LS_CTRL)
            begin
              if (!ctrl_match || busy)
                state <= mmtw_pkg::LS_IDLE;
              else
              begin
                state <= mmtw_pkg::LS_CTRL_ACK;
                sda_drive <= 1'b1;
                rd_mode <= shreg[mmtw_pkg::CTRL_RW_BIT];
                if (shreg[mmtw_pkg::CTRL_RW_BIT])
                begin
                  rd_addr <= cur_addr;
                  rd_req <= ~rd_req;
                end
              end
            end
            else if (state == mmtw_pkg::LS_ADDR)
            begin
              state <= mmtw_pkg::LS_ADDR_ACK;
              sda_drive <= 1'b1;
              cur_addr <= shreg;
              wr_base <= shreg;
              wr_count <= 7'h00;
              wr_full <= 1'b0;
            end
            else
            begin
              state <= mmtw_pkg::LS_WDATA_ACK;
              sda_drive <= 1'b1;
              wr_count <= wr_count + 7'h01;
              if (wr_count == 7'h7F)
                wr_full <= 1'b1;
            end
          end
        end
        mmtw_pkg::LS_CTRL_ACK:
        begin
          // ack bit over: first data bit or address phase
          if (scl_fall)
          begin
            if (rd_mode)
            begin
              state <= mmtw_pkg::LS_RDATA;
              shreg <= rd_data_l;
              sda_drive <= ~rd_data_l[7];
              bit_cnt <= 4'h1;
            end
            else
            begin
              state <= mmtw_pkg::LS_ADDR;
              sda_drive <= 1'b0;
            end
          end
        end
        mmtw_pkg::LS_ADDR_ACK, mmtw_pkg::LS_WDATA_ACK:
        begin
          // release after ack; more data may follow
          if (scl_fall)
          begin
            state <= mmtw_pkg::LS_WDATA;
            sda_drive <= 1'b0;
          end
        end
        mmtw_pkg::LS_RDATA:
        begin
          // transmit, next bit put out on scl fall
          if (byte_done)
          begin
            state <= mmtw_pkg::LS_RACK;
            sda_drive <= 1'b0;
          end
          else if (scl_fall)
          begin
            shreg <= {shreg[6:0], 1'b0};
            sda_drive <= ~shreg[6];
            bit_cnt <= bit_cnt + 4'h1;
          end
        end
        mmtw_pkg::LS_RACK:
        begin
          // sample initiator ack and fetch the next byte
          if (scl_rise)
          begin
            mack <= ~sda_s2;
            if (!sda_s2)
            begin
              cur_addr <= next_addr_inc;
              rd_addr <= next_addr_inc;
              rd_req <= ~rd_req;
            end
            else
              read_sent <= 1'b1;
          end
          else if (scl_fall)
          begin
            if (mack)
            begin
              state <= mmtw_pkg::LS_RDATA;
              shreg <= rd_data_l;
              sda_drive <= ~rd_data_l[7];
              bit_cnt <= 4'h1;
            end
            else
              state <= mmtw_pkg::LS_IDLE;
          end
        end
        default:
        begin
          // idle or unknown: wait for a start, sda released
          state <= mmtw_pkg::LS_IDLE;
          sda_drive <= 1'b0;
        end
      endcase
    end
  end

  // open-drain data pin
  assign sda_o = 1'b0;
  assign sda_oe_o = sda_drive;

  // ---------------- system clock domain ----------------
  logic rd_req_s1, rd_req_s2, rd_req_q; // read request sync
  logic rd_phase; // read address presented
  logic cm_req_s1, cm_req_s2, cm_req_q; // commit request sync
  mmtw_pkg::mmtw_commit_state_t cstate; // commit engine state
  logic [7:0] cm_idx; // byte of burst being written
  logic [7:0] cm_len; // bytes in burst
  logic [19:0] hold_cnt; // cycles since commit began
  logic [19:0] hold_lim; // limit chosen for this commit

  // commit length and the limit minus the crossing margin
  wire [7:0] burst_len = cm_cnt; // steady from the request until the answer
  wire [19:0] nv_lim = 20'(NV_HOLD_CYCLES - mmtw_pkg::SYNC_MARGIN_CYCLES);
  wire [19:0] vol_lim = 20'(VOL_HOLD_CYCLES - mmtw_pkg::SYNC_MARGIN_CYCLES);
  wire cm_new = cm_req_s2 ^ cm_req_q;
  wire [7:0] cm_addr = mmtw_pkg::page_add(wr_base, cm_idx);

  // request synchronisers
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_req_s1 <= 1'b0;
      rd_req_s2 <= 1'b0;
      rd_req_q <= 1'b0;
      cm_req_s1 <= 1'b0;
      cm_req_s2 <= 1'b0;
      cm_req_q <= 1'b0;
    end
    else
    begin
      rd_req_s1 <= rd_req;
      rd_req_s2 <= rd_req_s1;
      rd_req_q <= rd_req_s2;
      cm_req_s1 <= cm_req;
      cm_req_s2 <= cm_req_s1;
      cm_req_q <= cm_req_s2;
    end
  end

  // byte fetch: present address, capture a cycle later
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      mem_raddr_o <= 8'h00;
      rd_phase <= 1'b0;
      rd_data_x <= 8'h00;
      rd_ack <= 1'b0;
    end
    else if (rd_req_s2 ^ rd_req_q)
    begin
      mem_raddr_o <= rd_addr;
      rd_phase <= 1'b1;
    end
    else if (rd_phase)
    begin
      rd_data_x <= mem_rdata_i;
      rd_ack <= ~rd_ack;
      rd_phase <= 1'b0;
    end
  end

  // commit engine: one byte a cycle, then wait the write cycle out
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      cstate <= mmtw_pkg::CS_IDLE;
      cm_idx <= 8'h00;
      cm_len <= 8'h00;
      hold_cnt <= 20'h00000;
      hold_lim <= 20'h00000;
      mem_we_o <= 1'b0;
      mem_waddr_o <= 8'h00;
      mem_wdata_o <= 8'h00;
      cm_ack <= 1'b0;
    end
    else
    begin
      case (cstate)
        mmtw_pkg::CS_IDLE:
        begin
          mem_we_o <= 1'b0;
          if (cm_new)
          begin
            cstate <= mmtw_pkg::CS_WRITE;
            cm_idx <= 8'h00;
            cm_len <= burst_len;
            hold_cnt <= 20'h00000;
            hold_lim <= mem_nonvolatile_i ? nv_lim : vol_lim;
          end
        end
        mmtw_pkg::CS_WRITE:
        begin
          mem_we_o <= 1'b1;
          mem_waddr_o <= cm_addr;
          mem_wdata_o <= wbuf[cm_addr[6:0]];
          cm_idx <= cm_idx + 8'h01;
          hold_cnt <= hold_cnt + 20'h00001;
          if (cm_idx + 8'h01 == cm_len)
            cstate <= mmtw_pkg::CS_WAIT;
        end
        mmtw_pkg::CS_WAIT:
        begin
          // hold-off ends at write done or at the limit
          mem_we_o <= 1'b0;
          hold_cnt <= hold_cnt + 20'h00001;
          if ((!mem_busy_i && !mem_we_o) || hold_cnt >= hold_lim)
          begin
            cstate <= mmtw_pkg::CS_IDLE;
            cm_ack <= ~cm_ack;
          end
        end
        default:
          cstate <= mmtw_pkg::CS_IDLE;
      endcase
    end
  end

  assign holdoff_o = (cstate != mmtw_pkg::CS_IDLE);

  // ---------------- checks ----------------
  a_busy_ctrl_nack: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    state == mmtw_pkg::LS_CTRL && byte_done && busy && !start_det && !stop_det |=> !sda_drive && state == mmtw_pkg::LS_IDLE)
    else $error("control byte acknowledged during hold-off");
  a_foreign_ctrl_ignored: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    state == mmtw_pkg::LS_CTRL && byte_done && !ctrl_match && !start_det && !stop_det |=> !sda_drive [*2])
    else $error("foreign control byte answered");
  a_addr_loaded: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    state == mmtw_pkg::LS_ADDR && byte_done && !start_det && !stop_det |=> cur_addr == $past(shreg) && sda_drive)
    else $error("byte address not loaded at once");
  a_restart_keeps_addr: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    start_det |=> $stable(cur_addr) && !sda_drive && state == mmtw_pkg::LS_CTRL)
    else $error("restart changed address or kept driving");
  a_stop_read_inc: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    stop_det && read_sent |=> cur_addr == mmtw_pkg::page_add($past(cur_addr), 8'h01))
    else $error("address not advanced after read stop");
  a_commit_only_stop: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    $changed(cm_req) |-> $past(stop_det) && $past(state) == mmtw_pkg::LS_WDATA)
    else $error("commit without proper stop");
  a_page_wrap_upper: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    (state == mmtw_pkg::LS_RACK && scl_rise && !sda_s2 && !start_det && !stop_det) |=>
      cur_addr[7] == $past(cur_addr[7]) && cur_addr[6:0] == $past(cur_addr[6:0]) + 7'h01)
    else $error("sequential read address step wrong");
  a_write_stop_addr: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    $changed(cm_req) |-> cur_addr == $past(burst_end) && busy)
    else $error("address after write stop wrong");
  a_data_acked: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    state == mmtw_pkg::LS_WDATA && byte_done && !start_det && !stop_det |=> sda_drive && wr_count == $past(wr_count) + 7'h01)
    else $error("write data byte not acknowledged");
  a_read_first_bit: assert property (@(posedge link_clk_i) disable iff (!reset_n_i)
    state == mmtw_pkg::LS_CTRL_ACK && rd_mode && scl_fall && !start_det && !stop_det |=>
      state == mmtw_pkg::LS_RDATA && sda_drive == ~$past(rd_data_l[7]))
    else $error("read data not started");
  a_hold_bounded: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    cstate == mmtw_pkg::CS_WAIT |-> hold_cnt <= hold_lim + 20'(mmtw_pkg::PAGE_BYTES) ##1 cstate != mmtw_pkg::CS_WRITE)
    else $error("hold-off beyond its limit");
endmodule
`default_nettype wire

//--- test/mmtw_host.sv
// initiator model that drives the two-wire management link
`timescale 1ns/1ns
`default_nettype none
module mmtw_host (
  // pacing clock and resolved data wire
  input wire logic link_clk_i,
  input wire logic sda_i,
  // clock pin, and data pull (high = wire low)
  output logic scl_o,
  output logic pull_o,
  // one result strobe per ack bit or read byte
  output logic res_v_o,
  output logic [7:0] res_o
);
  // idle bus: clock high, data released
  initial
  begin
    scl_o = 1'b1;
    pull_o = 1'b0;
    res_v_o = 1'b0;
    res_o = 8'h00;
  end
  // one half bit, just after a link edge
  task automatic ph();
    repeat (10) @(posedge link_clk_i);
    #2;
  endtask
  // hand a result to the bench
  task automatic post(input logic [7:0] v);
    res_o = v;
    res_v_o = 1'b1;
    #1;
    res_v_o = 1'b0;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    pull_o = 1'b0;
    ph();
    scl_o = 1'b1;
    ph();
    pull_o = 1'b1;
    ph();
    scl_o = 1'b0;
  endtask
  // stop: data rises while clock high
  task automatic stop();
    pull_o = 1'b1;
    ph();
    scl_o = 1'b1;
    ph();
    pull_o = 1'b0;
    ph();
  endtask
  // one clock pulse; wire taken just before the fall
  task automatic pulse(output logic v);
    ph();
    scl_o = 1'b1;
    ph();
    v = sda_i;
    scl_o = 1'b0;
  endtask
  // n bits msb first; a whole byte also reads the answer
  task automatic wbyte(input logic [7:0] d, input int n);
    logic v;
    for (int i = 0; i < n; i++)
    begin
      pull_o = ~d[7 - i];
      pulse(v);
    end
    if (n == 8)
    begin
      pull_o = 1'b0;
      pulse(v);
      post({7'h00, v});
    end
  endtask
  // receive a byte, then ack to go on or nack to end
  task automatic rbyte(input logic nack);
    logic [7:0] b;
    logic v;
    b = 8'h00;
    pull_o = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      pulse(v);
      b = {b[6:0], v};
    end
    pull_o = ~nack;
    pulse(v);
    post(b);
  endtask
endmodule
`default_nettype wire

//--- test/test_module_mgmt_twowire_target.sv
// self-checking bench of the two-wire management target
`timescale 1ns/1ns
`default_nettype none
module test_module_mgmt_twowire_target;
  // short hold limits keep the run brief
  localparam int NV = 2000;
  localparam int VOL = 1000;
  localparam int CEIL = 60000;
  // clocks, reset, pins
  logic clk_i = 1'b0;
  logic link_clk = 1'b0;
  logic reset_n = 1'b0;
  wire logic sda;
  logic scl, pull, sda_o, sda_oe, res_v, mem_we, holdoff;
  logic [7:0] res, mem_raddr, mem_waddr, mem_wdata, mem_rdata;
  logic mem_nv = 1'b0;
  logic mem_busy;
  // storage model and the bench's own copy
  logic [7:0] mem [256];
  logic [7:0] sh [256];
  int busy_cnt = 0;
  int busy_len = 30;
  // expected link results and storage writes
  logic [7:0] lq [$];
  logic [15:0] wq [$];
  logic stopped = 1'b0;
  logic [7:0] cur = 8'h00;
  int hcnt = 0;
  int cycles = 0;
  int fail_count = 0;
  int samples_checked = 0;
  // open-drain wire with pull-up
  assign sda = ~(pull | (sda_oe & ~sda_o));
  assign mem_rdata = mem[mem_raddr];
  assign mem_busy = busy_cnt != 0;
  // system clock
  initial
  begin
    forever #10 clk_i = ~clk_i;
  end
  // link clock, unrelated phase
  initial
  begin
    #7;
    forever #16 link_clk = ~link_clk;
  end
  mmtw_target #(.NV_HOLD_CYCLES(NV), .VOL_HOLD_CYCLES(VOL)) dut (
    .clk_i(clk_i), .reset_n_i(reset_n), .link_clk_i(link_clk), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe_o(sda_oe), .mem_raddr_o(mem_raddr), .mem_rdata_i(mem_rdata),
    .mem_we_o(mem_we), .mem_waddr_o(mem_waddr), .mem_wdata_o(mem_wdata),
    .mem_nonvolatile_i(mem_nv), .mem_busy_i(mem_busy), .holdoff_o(holdoff));
  mmtw_host host (.link_clk_i(link_clk), .sda_i(sda), .scl_o(scl), .pull_o(pull),
    .res_v_o(res_v), .res_o(res));
  // count and report one comparison
  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e)
    begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, e, g);
    end
  endtask
  // verdict and end of run
  task automatic stop_test();
    $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // storage, busy time, hold-off length, write checks, timeout
  always @(posedge clk_i)
  begin
    cycles++;
    if (holdoff === 1'b1)
      hcnt++;
    if (mem_we === 1'b1)
    begin
      mem[mem_waddr] <= mem_wdata;
      busy_cnt <= busy_len;
      chk("write before stop", 16'h0001, {15'h0000, stopped});
      if (wq.size() == 0)
        chk("spare write", 16'h0000, 16'h0001);
      else
        chk("write", wq.pop_front(), {mem_waddr, mem_wdata});
    end
    else if (busy_cnt != 0)
      busy_cnt <= busy_cnt - 1;
    if (cycles == CEIL)
    begin
      fail_count++;
      stop_test();
    end
  end
  // link results against the oldest note
  always @(posedge res_v)
  begin
    if (lq.size() == 0)
      chk("spare link result", 16'h0000, 16'h0001);
    else
      chk("link", {8'h00, lq.pop_front()}, {8'h00, res});
  end
  // next address inside the page
  function automatic logic [7:0] inc(input logic [7:0] a);
    return {a[7], a[6:0] + 7'h01};
  endfunction
  // send a byte, expecting ack (0) or nack (1)
  task automatic send(input logic [7:0] d, input logic ack);
    lq.push_back({7'h00, ack});
    host.wbyte(d, 8);
  endtask
  // wait out the hold-off, then check its length
  task automatic wait_free();
    for (int i = 0; i < 3 * NV && holdoff !== 1'b0; i++)
      @(posedge clk_i);
    chk("hold-off length", 16'h0001, {15'h0000, hcnt <= (mem_nv ? NV : VOL)});
  endtask
  // write n random bytes from address a, end with stop
  task automatic do_write(input logic [7:0] a, input int n, input bit wt);
    logic [7:0] d;
    stopped = 1'b0;
    host.start();
    send(8'hA0, 1'b0);
    send(a, 1'b0);
    cur = a;
    for (int i = 0; i < n; i++)
    begin
      d = 8'($urandom);
      sh[cur] = d;
      wq.push_back({cur, d});
      send(d, 1'b0);
      cur = inc(cur);
    end
    stopped = 1'b1;
    hcnt = 0;
    host.stop();
    if (wt)
      wait_free();
  endtask
  // read n bytes from the current address, nack the last
  task automatic do_read(input int n);
    host.start();
    send(8'hA1, 1'b0);
    for (int i = 0; i < n; i++)
    begin
      lq.push_back(sh[cur]);
      host.rbyte(i == n - 1);
      cur = inc(cur);
    end
    host.stop();
  endtask
  // main sequence
  initial
  begin
    logic [7:0] a;
    void'($urandom(32'h025b9d2c));
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'($urandom);
      sh[i] = mem[i];
    end
    repeat (6) @(posedge clk_i);
    #2;
    reset_n = 1'b1;
    repeat (10) @(posedge link_clk);
    a = 8'($urandom);
    do_write(a, 1, 1'b1);
    do_read(2);
    $display("test single write done");
    do_write({a[7], 7'h7E}, 4, 1'b1);
    do_read(1);
    $display("test page wrap done");
    host.start();
    send(8'hA0, 1'b0);
    a = 8'($urandom);
    send(a, 1'b0);
    cur = a;
    do_read(3);
    do_read(1);
    $display("test random read done");
    host.start();
    send(8'hA0, 1'b0);
    send(a, 1'b0);
    cur = a;
    send(8'($urandom), 1'b0);
    do_read(1);
    $display("test restart after data done");
    for (int k = 0; k < 2; k++)
    begin
      mem_nv = k[0];
      busy_len = NV + 500;
      do_write(8'($urandom), 1, 1'b0);
      host.start();
      send(8'hA0, 1'b1);
      host.stop();
      wait_free();
      while (mem_busy === 1'b1)
        @(posedge clk_i);
    end
    busy_len = 30;
    $display("test hold-off done");
    for (int k = 0; k < 4; k++)
    begin
      host.start();
      send({7'h50 ^ 7'($urandom_range(1, 127)), k[0]}, 1'b1);
      host.stop();
    end
    for (int k = 0; k < 2; k++)
    begin
      host.start();
      send(8'hA0, 1'b0);
      host.wbyte(8'hFF, 3);
      if (k == 0)
        host.stop();
      do_read(1);
    end
    $display("test refusals done");
    stop_test();
  end
endmodule
`default_nettype wire
